/* include/phy_status_defines.vh */
// Purpose: Offsets, field positions, reset values for the status/bypass/counter bank
// Assumes: APB byte address = 4 * register index
// Notes: Definitions only
`ifndef PHY_STATUS_DEFINES_VH
`define PHY_STATUS_DEFINES_VH
// Register indices
`define IDX_FAST_STATUS 8'h10
`define IDX_BYPASS 8'h12
`define IDX_RX_ERR_CNT 8'h13
`define IDX_FALSE_CAR_CNT 8'h14
`define IDX_DISC_CNT 8'h15
`define IDX_SLOW_CTRL 8'h16
// Own control register: bit 0 soft reset pulse
`define IDX_SOFT_RESET 8'h1f
// Writable masks and reset values
`define BYPASS_WMASK 16'hfeb8
`define BYPASS_RESET 16'h0088
`define BYPASS_STICKY 16'h00b8
`define SLOW_WMASK 16'hfe01
`define SLOW_RESET 16'h3200
`define SLOW_STICKY 16'hfc01
`define SLOW_RETAIN_BIT 9
`define CNT_MAX 8'hff
`endif

/* rtl/phy_status_bypass_counters.v */
// Purpose: Management register bank: 100 Mb status, bypass control, error counters,
//          10 Mb extended control and status, reached over APB
// Assumes: Event and status inputs are synchronous to pclk
// Notes: Zero wait state slave; unmapped addresses read zero, pslverr low
`include "phy_status_defines.vh"
`default_nettype none

module phy_status_bypass_counters (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire pclk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Live status from the datapath
   input wire descrambler_locked,
   input wire fast_link_up,
   input wire slow_link_up,
   // Event pulses from the datapath
   input wire ev_lock_error,
   input wire ev_fast_disconnect,
   input wire ev_rx_error,
   input wire ev_tx_error,
   input wire ev_stream_start_delimiter_err,
   input wire ev_stream_end_delimiter_err,
   input wire ev_false_carrier,
   input wire ev_copper_disconnect,
   input wire ev_end_of_frame_error,
   input wire ev_slow_disconnect,
   // Controls to the datapath
   output wire transmit_disable,
   output wire bypass_4b5b,
   output wire bypass_scrambler,
   output wire bypass_descrambler,
   output wire bypass_coding_rx,
   output wire bypass_coding_tx,
   output wire bypass_link_fail_inhibit_timer,
   output wire automatic_crossover_forced_off,
   output wire pair_swap_correction_off,
   output wire polarity_correction_off,
   output wire parallel_detect_honour_ability,
   output wire force_slow_link_pass,
   output wire jabber_detect_off,
   output wire slow_echo_off,
   output wire signal_quality_error_test_off,
   output wire [1:0] squelch_level,
   output wire management_broadcast_write,
   output wire broadcast_write_strobe,
   output wire [4:0] broadcast_index,
   output wire [15:0] broadcast_data,
   output wire soft_reset_pulse
);

   reg [15:0] bypass_reg;
   reg [15:0] slow_reg;
   reg [7:0] status_flags_reg;
   reg [1:0] slow_flags_reg;
   reg [7:0] rx_err_cnt_reg;
   reg [7:0] false_car_cnt_reg;
   reg [7:0] disc_cnt_reg;
   reg soft_reset_reg;
   reg [15:0] rdata_next;

   wire [7:0] idx = paddr[9:2];
   wire aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
   wire access = psel && penable && pclk_en;
   wire wr = access && pwrite && aligned;
   wire rd = access && !pwrite && aligned;
   // Low 16 bits written only when both low lanes are strobed
   wire lanes_ok = pstrb[0] && pstrb[1];
   wire [15:0] wdata = pwdata[15:0];

   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Saturating counter with read clear; new event on read restarts at one
   function [7:0] count_next;
      input [7:0] cur;
      input ev;
      input clr;
      begin
         if (clr)
            count_next = ev ? 8'h01 : 8'h00;
         else if (ev && cur != `CNT_MAX)
            count_next = cur + 8'h01;
         else
            count_next = cur;
      end
   endfunction

   // Merge a write into a register, touching only writable bits
   function [15:0] merge_write;
      input [15:0] cur;
      input [15:0] data;
      input [15:0] wmask;
      begin
         merge_write = (cur & ~wmask) | (data & wmask);
      end
   endfunction

   // Soft reset value: sticky bits kept or defaulted
   function [15:0] soft_value;
      input [15:0] cur;
      input [15:0] dflt;
      input [15:0] sticky;
      input keep;
      begin
         soft_value = keep ? ((cur & sticky) | (dflt & ~sticky)) : dflt;
      end
   endfunction

   // Control registers and soft reset handling
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bypass_reg <= `BYPASS_RESET;
         slow_reg <= `SLOW_RESET;
         soft_reset_reg <= 1'b0;
      end else if (pclk_en) begin
         soft_reset_reg <= wr && lanes_ok && idx == `IDX_SOFT_RESET && pwdata[0];
         if (soft_reset_reg) begin
            bypass_reg <= soft_value(bypass_reg, `BYPASS_RESET, `BYPASS_STICKY,
                                     slow_reg[`SLOW_RETAIN_BIT]);
            slow_reg <= (soft_value(slow_reg, `SLOW_RESET, `SLOW_STICKY,
                                    slow_reg[`SLOW_RETAIN_BIT])
                         & ~(16'h0001 << `SLOW_RETAIN_BIT))
                        | (slow_reg & (16'h0001 << `SLOW_RETAIN_BIT));
         end else if (wr && lanes_ok) begin
            if (idx == `IDX_BYPASS)
               bypass_reg <= merge_write(bypass_reg, wdata, `BYPASS_WMASK);
            if (idx == `IDX_SLOW_CTRL)
               slow_reg <= merge_write(slow_reg, wdata, `SLOW_WMASK);
         end
      end
   end

   // Latched event flags; set wins over read clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_flags_reg <= 8'h00;
         slow_flags_reg <= 2'b00;
      end else if (pclk_en) begin
         status_flags_reg <= ((rd && idx == `IDX_FAST_STATUS) ? 8'h00 : status_flags_reg)
            | {ev_lock_error, ev_fast_disconnect, 2'b00, ev_rx_error, ev_tx_error,
               ev_stream_start_delimiter_err, ev_stream_end_delimiter_err};
         slow_flags_reg <= ((rd && idx == `IDX_SLOW_CTRL) ? 2'b00 : slow_flags_reg)
            | {ev_end_of_frame_error, ev_slow_disconnect};
      end
   end

   // Event counters
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_err_cnt_reg <= 8'h00;
         false_car_cnt_reg <= 8'h00;
         disc_cnt_reg <= 8'h00;
      end else if (pclk_en) begin
         rx_err_cnt_reg <= count_next(rx_err_cnt_reg, ev_rx_error,
                                      rd && idx == `IDX_RX_ERR_CNT);
         false_car_cnt_reg <= count_next(false_car_cnt_reg, ev_false_carrier,
                                         rd && idx == `IDX_FALSE_CAR_CNT);
         disc_cnt_reg <= count_next(disc_cnt_reg, ev_copper_disconnect,
                                    rd && idx == `IDX_DISC_CNT);
      end
   end

   // Read mux
   always @* begin
      rdata_next = 16'h0000;
      if (aligned) begin
         case (idx)
            `IDX_FAST_STATUS: rdata_next = {descrambler_locked, status_flags_reg[7:6],
                                            fast_link_up, status_flags_reg[3:0], 8'h00};
            `IDX_BYPASS: rdata_next = bypass_reg & `BYPASS_WMASK;
            `IDX_RX_ERR_CNT: rdata_next = {8'h00, rx_err_cnt_reg};
            `IDX_FALSE_CAR_CNT: rdata_next = {8'h00, false_car_cnt_reg};
            `IDX_DISC_CNT: rdata_next = {8'h00, disc_cnt_reg};
            `IDX_SLOW_CTRL: rdata_next = (slow_reg & `SLOW_WMASK)
                                         | {7'h00, slow_flags_reg, slow_link_up, 6'h00};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // Read data register, loaded in the setup cycle so it is valid at access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (pclk_en && psel && !penable && !pwrite)
         prdata <= {16'h0000, rdata_next};
   end

   assign transmit_disable = bypass_reg[15];
   assign bypass_4b5b = bypass_reg[14];
   assign bypass_scrambler = bypass_reg[13];
   assign bypass_descrambler = bypass_reg[12];
   assign bypass_coding_rx = bypass_reg[11];
   assign bypass_coding_tx = bypass_reg[10];
   assign bypass_link_fail_inhibit_timer = bypass_reg[9];
   assign automatic_crossover_forced_off = bypass_reg[7];
   assign pair_swap_correction_off = bypass_reg[5];
   assign polarity_correction_off = bypass_reg[4];
   assign parallel_detect_honour_ability = bypass_reg[3];
   assign force_slow_link_pass = slow_reg[15];
   assign jabber_detect_off = slow_reg[14];
   assign slow_echo_off = slow_reg[13];
   assign signal_quality_error_test_off = slow_reg[12];
   // squelch select, 10 raises the level
   assign squelch_level = slow_reg[11:10];
   // broadcast of every aligned write with both low lanes strobed while enabled
   assign management_broadcast_write = slow_reg[0];
   assign broadcast_write_strobe = wr && lanes_ok && slow_reg[0];
   assign broadcast_index = idx[4:0];
   assign broadcast_data = wdata;
   assign soft_reset_pulse = soft_reset_reg;

endmodule

`default_nettype wire

/* sim/mgmt_master.sv */
// Purpose: Management controller model, APB master
// Assumes: Slave answers through pready
// Notes: Write data inverted once released
`default_nettype none
module mgmt_master (
   // APB
   input wire logic pclk, pready,
   input wire logic [31:0] prdata,
   output logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0,
   output logic [3:0] pstrb = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Setup, access held until pready, then release
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      {psel, penable, pwdata} <= {2'b00, ~d};
   endtask
endmodule
`default_nettype wire

/* sim/phy_status_bypass_counters_props.sv */
// Purpose: Port properties of the status, bypass and counter bank
// Assumes: Zero wait APB slave, byte address is four times the index
// Notes: Bound from the bench top
`default_nettype none
module phy_status_bypass_counters_props (
   // APB side
   input wire logic pclk, presetn, pclk_en, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0] pstrb,
   // Status in, controls out
   input wire logic descrambler_locked, fast_link_up, transmit_disable,
   input wire logic automatic_crossover_forced_off, signal_quality_error_test_off,
   input wire logic [1:0] squelch_level,
   input wire logic management_broadcast_write, broadcast_write_strobe, soft_reset_pulse
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Taken full write, read access, read setup
   wire logic wr = psel & penable & pwrite & pclk_en & (pstrb[1:0] == 2'b11);
   wire logic rd = psel & penable & !pwrite & pclk_en;
   wire logic rs = psel & !penable & !pwrite & pclk_en;
   a_tx_disable_write:
      assert property (wr && paddr == 12'h048 |=> transmit_disable == $past(pwdata[15]))
      else $error("transmit disable");
   a_squelch_write:
      assert property (wr && paddr == 12'h058 |=> squelch_level == $past(pwdata[11:10]))
      else $error("squelch level");
   a_bcast_strobe:
      assert property (wr && management_broadcast_write |-> broadcast_write_strobe)
      else $error("broadcast strobe");
   a_soft_pulse:
      assert property (wr && paddr == 12'h07c && pwdata[0] |=> soft_reset_pulse ##1 !soft_reset_pulse)
      else $error("soft reset pulse");
   a_reserved_zero:
      assert property (rd && paddr == 12'h040 |-> prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0)
      else $error("reserved bits");
   a_status_live:
      assert property (rs && paddr == 12'h040 |=>
         prdata[15] == $past(descrambler_locked) && prdata[12] == $past(fast_link_up))
      else $error("live status");
   a_reset_default:
      assert property ($rose(presetn) |->
         !transmit_disable && automatic_crossover_forced_off && signal_quality_error_test_off)
      else $error("reset defaults");
   a_read_hold:
      assert property (!rs |=> $stable(prdata))
      else $error("read data moved");
   c_bypass_write: cover property (wr && paddr == 12'h048);
   c_soft_reset: cover property (soft_reset_pulse);
   c_broadcast: cover property (broadcast_write_strobe);
endmodule
`default_nettype wire

/* sim/phy_status_bypass_counters_tb_top.sv */
// Purpose: Self-checking bench for the status, bypass and counter bank
// Assumes: pclk_en held high
// Notes: Seeded events, levels and values
`default_nettype none
bind phy_status_bypass_counters phy_status_bypass_counters_props i_props (.*);
module phy_status_bypass_counters_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, pclk_en = 1'b1, psel, penable, pwrite, pready, pslverr;
   logic descrambler_locked = 1'b0, fast_link_up = 1'b0, slow_link_up = 1'b0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb;
   logic [15:0] v, broadcast_data;
   logic [9:0] ev = 10'h000;
   wire ev_lock_error, ev_fast_disconnect, ev_rx_error, ev_tx_error, ev_false_carrier,
      ev_stream_start_delimiter_err, ev_stream_end_delimiter_err, ev_copper_disconnect,
      ev_end_of_frame_error, ev_slow_disconnect;
   logic transmit_disable, bypass_4b5b, bypass_scrambler, bypass_descrambler, bypass_coding_rx,
      bypass_coding_tx, bypass_link_fail_inhibit_timer, automatic_crossover_forced_off,
      pair_swap_correction_off, polarity_correction_off, parallel_detect_honour_ability,
      force_slow_link_pass, jabber_detect_off, slow_echo_off, signal_quality_error_test_off,
      management_broadcast_write, broadcast_write_strobe, soft_reset_pulse;
   logic [1:0] squelch_level;
   logic [4:0] broadcast_index;
   integer seed = 32'h2c2b, miscompares = 0, samples_checked = 0, cyc = 0, n, k;
   int fl_ev[7] = '{0, 1, 3, 4, 5, 8, 9};
   logic [15:0] fl_v[7] = '{16'h4000, 16'h2000, 16'h0400, 16'h0200, 16'h0100, 16'h3300, 16'h3280};
   // Event lines, one bit each
   assign {ev_slow_disconnect, ev_end_of_frame_error, ev_copper_disconnect, ev_false_carrier,
      ev_stream_end_delimiter_err, ev_stream_start_delimiter_err, ev_tx_error, ev_rx_error,
      ev_fast_disconnect, ev_lock_error} = ev;
   phy_status_bypass_counters i_phy_status_bypass_counters (.*);
   mgmt_master i_mgmt_master (.*);
   function logic [31:0] sat(input integer c);
      return (c > 255) ? 32'hff : c;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] exp);
      i_mgmt_master.xfer(1'b0, a, 32'h0, 4'h0, r);
      chk(r, exp);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      i_mgmt_master.xfer(1'b1, a, d, s, r);
   endtask
   // One event per cycle for c cycles
   task pulse(input integer i, input integer c);
      ev[i] <= 1'b1;
      repeat (c) @(posedge pclk);
      ev <= 10'h000;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial forever #4 pclk = ~pclk;
   // Cut a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test;
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rchk(12'h048, 32'h0088);
      rchk(12'h058, 32'h3200);
      rchk(12'h044, 32'h0);
      // Counters saturate and clear on read
      for (k = 0; k < 3; k++) begin
         n = k ? 1 + {$random(seed)} % 260 : 300;
         pulse(k ? k + 5 : 2, n);
         rchk(12'(12'h04c + 4 * k), sat(n));
         rchk(12'(12'h04c + 4 * k), 32'h0);
      end
      rchk(12'h040, 32'h0800);
      // Latched flags set by events, cleared by read
      for (k = 0; k < 7; k++) begin
         pulse(fl_ev[k], 1);
         rchk(k < 5 ? 12'h040 : 12'h058, fl_v[k]);
         rchk(k < 5 ? 12'h040 : 12'h058, k < 5 ? 32'h0 : 32'h3200);
      end
      repeat (4) begin
         v = $random(seed);
         descrambler_locked <= v[0];
         fast_link_up <= v[1];
         slow_link_up <= v[2];
         rchk(12'h040, {v[0], 2'b00, v[1], 12'h000});
         rchk(12'h058, 16'h3200 | {v[2], 6'h00});
      end
      // Random writes; partial lane write refused
      repeat (6) begin
         v = $random(seed);
         wr(12'h048, v, 4'hf);
         wr(12'h048, ~v, 4'h1);
         rchk(12'h048, v & 16'hfeb8);
         wr(12'h058, v, 4'hf);
         rchk(12'h058, v & 16'hfe01 | {slow_link_up, 6'h00});
      end
      // Soft reset with and without retention
      wr(12'h058, 32'h0200, 4'hf);
      wr(12'h048, 32'h00b0, 4'hf);
      wr(12'h07c, 32'h1, 4'hf);
      rchk(12'h048, 32'h00b0);
      wr(12'h058, 32'h0, 4'hf);
      wr(12'h07c, 32'h1, 4'hf);
      rchk(12'h048, 32'h0088);
      rchk(12'h058, 32'h3000 | {slow_link_up, 6'h00});
      wr(12'h058, 32'h0001, 4'hf);
      wr(12'h048, 32'h8000, 4'hf);
      #1;
      chk(management_broadcast_write, 1'b1);
      chk(transmit_disable, 1'b1);
      chk({bypass_4b5b, bypass_scrambler, bypass_descrambler}, 32'h0);
      chk({bypass_coding_rx, bypass_coding_tx}, 32'h0);
      chk(bypass_link_fail_inhibit_timer, 1'b0);
      chk({automatic_crossover_forced_off, pair_swap_correction_off}, 32'h0);
      chk({polarity_correction_off, parallel_detect_honour_ability}, 32'h0);
      chk({force_slow_link_pass, jabber_detect_off}, 32'h0);
      chk({slow_echo_off, signal_quality_error_test_off, squelch_level}, 32'h0);
      finish_test;
   end
endmodule
`default_nettype wire
